// ---- hdl/wpq_consts.svh ----
// Offsets, field positions, reset values and masks of the watchpoint qualifier.
`ifndef WPQ_CONSTS_SVH
`define WPQ_CONSTS_SVH

// ====================
// Register byte offsets on the register bus.
`define WPQ_OFS_VALUE 8'h00
`define WPQ_OFS_CTRL 8'h04
`define WPQ_OFS_IRQ_STAT 8'h08
`define WPQ_OFS_IRQ_MASK 8'h0C
`define WPQ_OFS_HIT_CNT 8'h10

// ====================
// Control register field positions.
`define WPQ_CTL_EN 0
`define WPQ_CTL_PRIV_LO 1
`define WPQ_CTL_PRIV_HI 2
`define WPQ_CTL_DIR_LO 3
`define WPQ_CTL_DIR_HI 4
`define WPQ_CTL_LANE_LO 5
`define WPQ_CTL_LANE_HI 8
`define WPQ_CTL_SEC_LO 14
`define WPQ_CTL_SEC_HI 15
`define WPQ_CTL_PAIR_LO 16
`define WPQ_CTL_PAIR_HI 19
`define WPQ_CTL_LINK 20
`define WPQ_CTL_AMASK_LO 24
`define WPQ_CTL_AMASK_HI 28

// ====================
// Writable bits, reset values and status bit positions.
`define WPQ_CTRL_WMASK 32'h1F1FC1FF
`define WPQ_VALUE_WMASK 32'hFFFFFFFC
`define WPQ_CTRL_RESET 32'h00000000
`define WPQ_VALUE_RESET 32'h00000000
`define WPQ_IRQ_WIDTH 2
`define WPQ_IRQ_HIT 0
`define WPQ_IRQ_RSVD_CFG 1

`endif

// ---- hdl/wpq_pkg.sv ----
// Types shared by the watchpoint qualifier and its bench.
package wpq_pkg;

    // ====================
    // Kind of data access presented by the load/store path.
    typedef enum logic [2:0] {
        WPQ_ACC_LOAD,
        WPQ_ACC_STORE,
        WPQ_ACC_LOAD_EXCL,
        WPQ_ACC_STORE_EXCL,
        WPQ_ACC_SWAP,
        WPQ_ACC_CACHE_MAINT
    } wpq_acc_kind_t;

endpackage : wpq_pkg

// ---- hdl/wpq_code_filter.sv ----
// Generic two-bit code filter used for security, direction and privilege.
`timescale 1ns/1ps

// Bit 0 of the code admits accesses of class A, bit 1 admits class B.
module wpq_code_filter #(
    parameter bit ZERO_ALL = 1'b0,   // Code 00 admits every access.
    parameter bit ONES_RSVD = 1'b0   // Code 11 is reserved and never admits.
) (
    input wire logic [1:0] code_i,
    input wire logic class_a_i,
    input wire logic class_b_i,
    output logic pass_o,
    output logic rsvd_o
);

    // ====================
    // Decode. Reserved codes never pass, so a half-programmed slot stays quiet.
    always_comb begin
        rsvd_o = (ONES_RSVD && code_i == 2'h3) || (!ZERO_ALL && code_i == 2'h0);
        if (rsvd_o) begin
            pass_o = 1'b0;
        end else if (ZERO_ALL && code_i == 2'h0) begin
            pass_o = 1'b1;
        end else begin
            pass_o = (code_i[0] && class_a_i) || (code_i[1] && class_b_i);
        end
    end

endmodule : wpq_code_filter

// ---- hdl/wpq_addr_match.sv ----
// Word address and byte-lane comparison against the watched address.
`timescale 1ns/1ps

module wpq_addr_match #(
    parameter int AW = 32,   // Width of the data virtual address.
    parameter int LANES = 4  // Byte lanes in one word.
) (
    input wire logic [AW-1:0] watch_addr_i,
    input wire logic [4:0] addr_mask_i,
    input wire logic [LANES-1:0] lane_sel_i,
    input wire logic [AW-1:0] acc_addr_i,
    input wire logic [LANES-1:0] acc_lanes_i,
    output logic match_o
);

    logic [AW-1:0] ign_bits; // Low address bits left out of the compare.
    logic word_hit;          // Word part of the address agrees.

    // ====================
    // A nonzero mask widens the watched range to a power-of-two block.
    always_comb begin
        ign_bits = '0;
        for (int i = 2; i < AW; i++) begin
            if (addr_mask_i != 5'h00 && i < int'(addr_mask_i)) begin
                ign_bits[i] = 1'b1;
            end
        end
        ign_bits[1:0] = 2'h3;
        word_hit = ((watch_addr_i ^ acc_addr_i) & ~ign_bits) == '0;
        // Under a mask every lane of the block counts; otherwise only the
        // selected bytes of the watched word do.
        if (addr_mask_i != 5'h00) begin
            match_o = word_hit && (acc_lanes_i != '0);
        end else begin
            match_o = word_hit && ((acc_lanes_i & lane_sel_i) != '0);
        end
    end

endmodule : wpq_addr_match

// ---- hdl/wpq_qualifier.sv ----
// Watchpoint qualifier: register file, access filters and event output.
//
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "wpq_consts.svh"

module wpq_qualifier #(
    parameter int PAIRS = 16,            // Breakpoint pairs offering context matches.
    parameter bit STREX_ANY_MON = 1'b0   // Let store-exclusives hit whatever the monitor says.
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Classic Wishbone slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Access stream from the load/store path.
    input wire logic acc_valid_i,
    input wire wpq_pkg::wpq_acc_kind_t acc_kind_i,
    input wire logic [31:0] data_virtual_addr_i,
    input wire logic [3:0] acc_lanes_i,
    input wire logic acc_secure_i,
    input wire logic acc_priv_i,
    input wire logic acc_excl_pass_i,
    input wire logic [PAIRS-1:0] breakpoint_pair_ctx_i,
    // Results.
    output logic wp_event_o,
    output logic irq_o
);

    // ======================================================================
    // Register state.
    logic [31:0] watchpoint_value_q;   // Watched data virtual address.
    logic [31:0] watchpoint_control_q; // Enable and qualifier fields.
    logic [`WPQ_IRQ_WIDTH-1:0] irq_stat_q; // Sticky event bits.
    logic [`WPQ_IRQ_WIDTH-1:0] irq_stat_d;
    logic [`WPQ_IRQ_WIDTH-1:0] irq_mask_q; // Interrupt enables.
    logic [31:0] hit_cnt_q;            // Count of raised events.
    logic [31:0] dat_q;
    logic ack_q;
    logic event_q;
    logic irq_q;

    // ======================================================================
    // Bus decode.
    logic bus_req;   // A new bus cycle is waiting for its answer.
    logic bus_wr;    // That cycle writes.
    logic [31:0] wmask_bytes; // Byte enables widened to bits.

    // The ack drops for one cycle after each answer so that a master holding
    // stb for a single transfer is never answered twice.
    assign bus_req = cyc_i && stb_i && !ack_q;
    assign bus_wr = bus_req && we_i;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask_bytes[b*8 +: 8] = {8{sel_i[b]}};
        end
    end

    // ======================================================================
    // Field views of the control register.
    logic ctl_en;
    logic [1:0] ctl_priv;
    logic [1:0] ctl_dir;
    logic [3:0] ctl_lanes;
    logic [1:0] ctl_sec;
    logic [3:0] ctl_pair;
    logic ctl_link;
    logic [4:0] ctl_amask;

    assign ctl_en = watchpoint_control_q[`WPQ_CTL_EN];
    assign ctl_priv = watchpoint_control_q[`WPQ_CTL_PRIV_HI:`WPQ_CTL_PRIV_LO];
    assign ctl_dir = watchpoint_control_q[`WPQ_CTL_DIR_HI:`WPQ_CTL_DIR_LO];
    assign ctl_lanes = watchpoint_control_q[`WPQ_CTL_LANE_HI:`WPQ_CTL_LANE_LO];
    assign ctl_sec = watchpoint_control_q[`WPQ_CTL_SEC_HI:`WPQ_CTL_SEC_LO];
    assign ctl_pair = watchpoint_control_q[`WPQ_CTL_PAIR_HI:`WPQ_CTL_PAIR_LO];
    assign ctl_link = watchpoint_control_q[`WPQ_CTL_LINK];
    assign ctl_amask = watchpoint_control_q[`WPQ_CTL_AMASK_HI:`WPQ_CTL_AMASK_LO];

    // ======================================================================
    // Watched address register.
    // The two low bits are never stored, so they read as zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            watchpoint_value_q <= `WPQ_VALUE_RESET;
        end else if (bus_wr && adr_i == `WPQ_OFS_VALUE) begin
            watchpoint_value_q <= (watchpoint_value_q & ~(wmask_bytes & `WPQ_VALUE_WMASK))
                                | (dat_i & wmask_bytes & `WPQ_VALUE_WMASK);
        end
    end

    // ======================================================================
    // Control register.
    // Reset leaves the watchpoint disabled; reserved bits are never stored.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            watchpoint_control_q <= `WPQ_CTRL_RESET;
        end else if (bus_wr && adr_i == `WPQ_OFS_CTRL) begin
            watchpoint_control_q <= (watchpoint_control_q & ~(wmask_bytes & `WPQ_CTRL_WMASK))
                                  | (dat_i & wmask_bytes & `WPQ_CTRL_WMASK);
        end
    end

    // ======================================================================
    // Access classification.
    logic is_load_side;  // Access may satisfy a load code.
    logic is_store_side; // Access may satisfy a store code.
    logic strex_ok;      // Store-exclusive allowed to count.

    always_comb begin
        // A failed store-exclusive writes nothing, so by default it is not
        // watched; the parameter trades that for catching every attempt.
        strex_ok = acc_excl_pass_i || STREX_ANY_MON;
        is_load_side = 1'b0;
        is_store_side = 1'b0;
        unique case (acc_kind_i)
            wpq_pkg::WPQ_ACC_LOAD: begin
                is_load_side = 1'b1;
            end
            wpq_pkg::WPQ_ACC_LOAD_EXCL: begin
                is_load_side = 1'b1;
            end
            wpq_pkg::WPQ_ACC_STORE: begin
                is_store_side = 1'b1;
            end
            wpq_pkg::WPQ_ACC_STORE_EXCL: begin
                is_store_side = strex_ok;
            end
            wpq_pkg::WPQ_ACC_SWAP: begin
                // A swap both reads and writes, so any legal code sees it.
                is_load_side = 1'b1;
                is_store_side = 1'b1;
            end
            wpq_pkg::WPQ_ACC_CACHE_MAINT: begin
                // Maintenance operations never raise watchpoint events.
                is_load_side = 1'b0;
            end
            default: begin
                // Unused encodings of the kind are treated as no access.
                is_load_side = 1'b0;
            end
        endcase
    end

    // ======================================================================
    // Qualifier filters.
    logic sec_pass;
    logic dir_pass;
    logic priv_pass;
    logic addr_pass;
    logic link_pass;
    logic sec_rsvd;
    logic dir_rsvd;
    logic priv_rsvd;

    // Security: bit 0 non-secure, bit 1 secure, 00 both, 11 reserved.
    wpq_code_filter #(
        .ZERO_ALL(1'b1),
        .ONES_RSVD(1'b1)
    ) u_sec_filter (
        .code_i(ctl_sec),
        .class_a_i(!acc_secure_i),
        .class_b_i(acc_secure_i),
        .pass_o(sec_pass),
        .rsvd_o(sec_rsvd)
    );

    // Direction: bit 0 loads, bit 1 stores, 11 either, 00 reserved.
    wpq_code_filter #(
        .ZERO_ALL(1'b0),
        .ONES_RSVD(1'b0)
    ) u_dir_filter (
        .code_i(ctl_dir),
        .class_a_i(is_load_side),
        .class_b_i(is_store_side),
        .pass_o(dir_pass),
        .rsvd_o(dir_rsvd)
    );

    // Privilege: the access's own attribute is used, since a privileged mode
    // may still issue unprivileged accesses.
    wpq_code_filter #(
        .ZERO_ALL(1'b0),
        .ONES_RSVD(1'b0)
    ) u_priv_filter (
        .code_i(ctl_priv),
        .class_a_i(acc_priv_i),
        .class_b_i(!acc_priv_i),
        .pass_o(priv_pass),
        .rsvd_o(priv_rsvd)
    );

    // Address and byte lanes.
    wpq_addr_match #(
        .AW(32),
        .LANES(4)
    ) u_addr_match (
        .watch_addr_i(watchpoint_value_q),
        .addr_mask_i(ctl_amask),
        .lane_sel_i(ctl_lanes),
        .acc_addr_i(data_virtual_addr_i),
        .acc_lanes_i(acc_lanes_i),
        .match_o(addr_pass)
    );

    // A link to a pair beyond the implemented count never matches.
    always_comb begin
        link_pass = 1'b1;
        if (ctl_link) begin
            link_pass = (int'(ctl_pair) < PAIRS) && breakpoint_pair_ctx_i[ctl_pair];
        end
    end

    // ======================================================================
    // Hit decision.
    logic hit;     // Every qualifier agrees on this access.
    logic cfg_bad; // Enabled with a reserved code programmed.

    assign hit = acc_valid_i && ctl_en && addr_pass && sec_pass
              && dir_pass && priv_pass && link_pass;
    assign cfg_bad = ctl_en && (sec_rsvd || dir_rsvd || priv_rsvd);

    // The event is registered so the abort logic sees a clean pulse one
    // cycle after the access.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_q <= 1'b0;
        end else begin
            event_q <= hit;
        end
    end

    // Events counted for software; wraps silently at the top.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hit_cnt_q <= 32'h00000000;
        end else if (hit) begin
            hit_cnt_q <= hit_cnt_q + 32'h00000001;
        end
    end

    // ======================================================================
    // Interrupt status and mask.
    // A new event in the same cycle as a write-one-to-clear stays set.
    always_comb begin
        irq_stat_d = irq_stat_q;
        if (bus_wr && adr_i == `WPQ_OFS_IRQ_STAT && sel_i[0]) begin
            irq_stat_d = irq_stat_q & ~dat_i[`WPQ_IRQ_WIDTH-1:0];
        end
        irq_stat_d[`WPQ_IRQ_HIT] = irq_stat_d[`WPQ_IRQ_HIT] | hit;
        irq_stat_d[`WPQ_IRQ_RSVD_CFG] = irq_stat_d[`WPQ_IRQ_RSVD_CFG] | cfg_bad;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_q <= '0;
        end else if (bus_wr && adr_i == `WPQ_OFS_IRQ_MASK && sel_i[0]) begin
            irq_mask_q <= dat_i[`WPQ_IRQ_WIDTH-1:0];
        end
    end

    // Built from the next status so the line follows the sticky bits with
    // no extra cycle of lag.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else if (bus_wr && adr_i == `WPQ_OFS_IRQ_MASK && sel_i[0]) begin
            irq_q <= |(irq_stat_d & dat_i[`WPQ_IRQ_WIDTH-1:0]);
        end else begin
            irq_q <= |(irq_stat_d & irq_mask_q);
        end
    end

    // ======================================================================
    // Read data and acknowledge.
    // Unmapped offsets answer with zero and ignore writes.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h00000000;
        end else if (bus_req && !we_i) begin
            unique case (adr_i)
                `WPQ_OFS_VALUE: begin
                    dat_q <= watchpoint_value_q & `WPQ_VALUE_WMASK;
                end
                `WPQ_OFS_CTRL: begin
                    dat_q <= watchpoint_control_q & `WPQ_CTRL_WMASK;
                end
                `WPQ_OFS_IRQ_STAT: begin
                    dat_q <= {30'h00000000, irq_stat_q};
                end
                `WPQ_OFS_IRQ_MASK: begin
                    dat_q <= {30'h00000000, irq_mask_q};
                end
                `WPQ_OFS_HIT_CNT: begin
                    dat_q <= hit_cnt_q;
                end
                default: begin
                    dat_q <= 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req;
        end
    end

    // ======================================================================
    // Outputs, each straight from a flip-flop.
    assign dat_o = dat_q;
    assign ack_o = ack_q;
    assign wp_event_o = event_q;
    assign irq_o = irq_q;

endmodule : wpq_qualifier

// ---- tb/wpq_qualifier_assertions.sv ----
// Port-level assertions for the watchpoint qualifier, with their bind.
`timescale 1ns/1ps

module wpq_qualifier_checker #(
    parameter int PAIRS = 16,
    parameter bit STREX_ANY_MON = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic acc_valid_i,
    input wire wpq_pkg::wpq_acc_kind_t acc_kind_i,
    input wire logic [31:0] data_virtual_addr_i,
    input wire logic [3:0] acc_lanes_i,
    input wire logic acc_secure_i,
    input wire logic acc_priv_i,
    input wire logic acc_excl_pass_i,
    input wire logic [PAIRS-1:0] breakpoint_pair_ctx_i,
    input wire logic wp_event_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ====================
    // Shadow registers, rebuilt from taken writes so filters can be judged.
    logic take, msk_q, sec_ok, dir_ok, prv_ok, lnk, hit;
    logic [31:0] bm, ctl_q, val_q;
    assign take = cyc_i && stb_i && !ack_o;
    assign bm = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_q <= 32'h00000000;
            val_q <= 32'h00000000;
            msk_q <= 1'b0;
        end else if (take && we_i) begin
            if (adr_i == 8'h00) val_q <= (val_q & ~bm) | (dat_i & bm & 32'hFFFFFFFC);
            if (adr_i == 8'h04) ctl_q <= (ctl_q & ~bm) | (dat_i & bm & 32'h1F1FC1FF);
            if (adr_i == 8'h0C && sel_i[0]) msk_q <= dat_i[0];
        end
    end
    // Expected qualification of the access now on the port.
    always_comb begin
        sec_ok = ctl_q[15:14] == 2'h0 || ctl_q[15:14] == {acc_secure_i, !acc_secure_i};
        prv_ok = (ctl_q[1] && acc_priv_i) || (ctl_q[2] && !acc_priv_i);
        lnk = ctl_q[19:16] < PAIRS && breakpoint_pair_ctx_i[ctl_q[19:16]];
        case (acc_kind_i)
            wpq_pkg::WPQ_ACC_LOAD, wpq_pkg::WPQ_ACC_LOAD_EXCL: dir_ok = ctl_q[3];
            wpq_pkg::WPQ_ACC_STORE: dir_ok = ctl_q[4];
            wpq_pkg::WPQ_ACC_STORE_EXCL: dir_ok = ctl_q[4] && (acc_excl_pass_i || STREX_ANY_MON);
            wpq_pkg::WPQ_ACC_SWAP: dir_ok = ctl_q[4] || ctl_q[3];
            default: dir_ok = 1'b0;
        endcase
        hit = ctl_q[0] && sec_ok && dir_ok && prv_ok && (!ctl_q[20] || lnk)
            && data_virtual_addr_i[31:2] == val_q[31:2] && |(acc_lanes_i & ctl_q[8:5]);
    end
    // ====================
    // Assertions.
    a_hit_exact: assert property (acc_valid_i && ctl_q[28:24] == 5'h00 |=> wp_event_o == $past(hit))
        else $error("wrong event");
    a_idle_quiet: assert property (!acc_valid_i |=> !wp_event_o)
        else $error("event when idle");
    a_disabled_quiet: assert property (acc_valid_i && !ctl_q[0] |=> !wp_event_o)
        else $error("event while disabled");
    a_sec_filter: assert property (acc_valid_i && !sec_ok |=> !wp_event_o)
        else $error("security filter");
    a_dir_filter: assert property (acc_valid_i && !dir_ok |=> !wp_event_o)
        else $error("direction filter");
    a_priv_filter: assert property (acc_valid_i && !prv_ok |=> !wp_event_o)
        else $error("privilege filter");
    a_lane_gate: assert property (acc_valid_i && ctl_q[28:24] == 5'h00 && (acc_lanes_i & ctl_q[8:5]) == 4'h0
        |=> !wp_event_o)
        else $error("lane filter");
    a_link_gate: assert property (acc_valid_i && ctl_q[20] && !lnk |=> !wp_event_o)
        else $error("link filter");
    a_read_ctrl: assert property (take && !we_i && adr_i == 8'h04 |=> ack_o && dat_o == ctl_q)
        else $error("control readback");
    a_read_value: assert property (take && !we_i && adr_i == 8'h00 |=> ack_o && dat_o == val_q)
        else $error("value readback");
    a_ack_pulse: assert property (take |=> ack_o ##1 !ack_o)
        else $error("ack pulse");
    a_irq_follow: assert property (wp_event_o && msk_q |-> irq_o)
        else $error("irq missing");
endmodule : wpq_qualifier_checker

bind wpq_qualifier wpq_qualifier_checker #(.PAIRS(PAIRS), .STREX_ANY_MON(STREX_ANY_MON)) u_chk (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .acc_valid_i,
    .acc_kind_i, .data_virtual_addr_i, .acc_lanes_i, .acc_secure_i, .acc_priv_i, .acc_excl_pass_i,
    .breakpoint_pair_ctx_i, .wp_event_o, .irq_o);

// ---- tb/wpq_lsu_model.sv ----
// Behavioural load/store path presenting data accesses to the qualifier.
`timescale 1ns/1ps

module wpq_lsu_model #(
    parameter int PAIRS = 16
) (
    input wire logic clk_i,
    output logic acc_valid_o,
    output wpq_pkg::wpq_acc_kind_t acc_kind_o,
    output logic [31:0] addr_o,
    output logic [3:0] lanes_o,
    output logic secure_o,
    output logic priv_o,
    output logic excl_pass_o,
    output logic [PAIRS-1:0] ctx_o
);
    initial begin
        acc_kind_o = wpq_pkg::WPQ_ACC_CACHE_MAINT;
        {acc_valid_o, addr_o, lanes_o, secure_o, priv_o, excl_pass_o, ctx_o} = '0;
    end
    // ====================
    // One access held for n cycles; afterwards the address, lane and attribute lines show stale inverted
    // values so a design that samples outside valid cannot get lucky.
    task automatic issue(input wpq_pkg::wpq_acc_kind_t k, input logic [31:0] a, input logic [3:0] l,
                         input logic s, input logic p, input logic x, input logic [PAIRS-1:0] c, input int n);
        @(posedge clk_i);
        acc_valid_o <= 1'b1;
        acc_kind_o <= k;
        addr_o <= a;
        lanes_o <= l;
        secure_o <= s;
        priv_o <= p;
        excl_pass_o <= x;
        ctx_o <= c;
        repeat (n) @(posedge clk_i);
        acc_valid_o <= 1'b0;
        addr_o <= ~a;
        lanes_o <= ~l;
        secure_o <= ~s;
        priv_o <= ~p;
        excl_pass_o <= ~x;
    endtask : issue
endmodule : wpq_lsu_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the watchpoint qualifier.
`timescale 1ns/1ps

module tb_top;
    // ====================
    // Signals, counters and instances.
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, acc_valid_i, acc_secure_i, acc_priv_i;
    logic acc_excl_pass_i, wp_event_o, irq_o;
    logic [7:0] adr_i;
    logic [3:0] sel_i, acc_lanes_i;
    logic [31:0] dat_i, dat_o, data_virtual_addr_i, rd_v, cnt_v;
    logic [15:0] breakpoint_pair_ctx_i, ctx_v;
    wpq_pkg::wpq_acc_kind_t acc_kind_i;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;

    wpq_qualifier DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .acc_valid_i, .acc_kind_i, .data_virtual_addr_i, .acc_lanes_i, .acc_secure_i, .acc_priv_i,
        .acc_excl_pass_i, .breakpoint_pair_ctx_i, .wp_event_o, .irq_o);
    wpq_lsu_model lsu (.clk_i, .acc_valid_o(acc_valid_i), .acc_kind_o(acc_kind_i),
        .addr_o(data_virtual_addr_i), .lanes_o(acc_lanes_i), .secure_o(acc_secure_i),
        .priv_o(acc_priv_i), .excl_pass_o(acc_excl_pass_i), .ctx_o(breakpoint_pair_ctx_i));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // The whole run needs well under a thousand cycles.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            complete_run();
        end
    end
    // ====================
    // Shared tasks.
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Classic Wishbone cycle; read data is taken at the ack edge.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        rd_v = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : bus
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(rd_v, exp);
    endtask : rdchk
    function automatic logic [31:0] cw(input logic [1:0] s, input logic [3:0] l, input logic [1:0] d,
                                       input logic [1:0] p, input logic e);
        return {16'h0000, s, 5'h00, l, d, p, e};
    endfunction : cw
    // Kinds admitted per direction code, bit n for kind n, with the monitor passed.
    localparam logic [5:0] DIR_HITS [4] = '{6'h00, 6'h15, 6'h1A, 6'h1F};
    // Program control, present one access, judge the event a cycle later.
    task automatic probe(input logic [31:0] c, input int k, input logic [31:0] a, input logic [3:0] l,
                         input logic s, input logic p, input logic x, input logic e);
        bus(1'b1, 8'h04, c, 4'hF);
        lsu.issue(wpq_pkg::wpq_acc_kind_t'(k[2:0]), a, l, s, p, x, ctx_v, 1);
        #1;
        chk(32'(wp_event_o), 32'(e));
    endtask : probe
    // ====================
    // Scenarios.
    task automatic t_regs();
        for (int i = 0; i < 6; i++) rdchk(8'(i * 4), 32'h0);
        bus(1'b1, 8'h04, 32'hFFFFFFFF, 4'hF);
        rdchk(8'h04, 32'h1F1FC1FF);
        bus(1'b1, 8'h04, 32'h0, 4'h1);
        rdchk(8'h04, 32'h1F1FC100);
        bus(1'b1, 8'h00, 32'h1237, 4'hF);
        rdchk(8'h00, 32'h1234);
        bus(1'b1, 8'h14, 32'hFFFFFFFF, 4'hF);
        rdchk(8'h14, 32'h0);
        $display("test regs done");
    endtask : t_regs
    task automatic t_filters();
        for (int s = 0; s < 4; s++)
            for (int x = 0; x < 2; x++)
                probe(cw(2'(s), 4'hF, 2'h3, 2'h3, 1'b1), 0, 32'h1234, 4'hF, x[0], 1'b1, 1'b1,
                      s == 0 || s == (x ? 2 : 1));
        for (int d = 0; d < 4; d++)
            for (int k = 0; k < 6; k++)
                probe(cw(2'h0, 4'hF, 2'(d), 2'h3, 1'b1), k, 32'h1234, 4'hF, 1'b0, 1'b1, 1'b1,
                      DIR_HITS[d][k]);
        probe(cw(2'h0, 4'hF, 2'h3, 2'h3, 1'b1), 3, 32'h1234, 4'hF, 1'b0, 1'b1, 1'b0, 1'b0);
        for (int p = 0; p < 4; p++)
            for (int x = 0; x < 2; x++)
                probe(cw(2'h0, 4'hF, 2'h3, 2'(p), 1'b1), 0, 32'h1234, 4'hF, 1'b0, x[0], 1'b1,
                      (p[0] && x[0]) || (p[1] && !x[0]));
        $display("test filters done");
    endtask : t_filters
    task automatic t_lanes_link();
        probe(cw(2'h0, 4'h2, 2'h3, 2'h3, 1'b1), 0, 32'h1234, 4'h1, 1'b0, 1'b1, 1'b1, 1'b0);
        probe(cw(2'h0, 4'h2, 2'h3, 2'h3, 1'b1), 0, 32'h1234, 4'h2, 1'b0, 1'b1, 1'b1, 1'b1);
        probe(cw(2'h0, 4'hF, 2'h3, 2'h3, 1'b1), 0, 32'h1238, 4'hF, 1'b0, 1'b1, 1'b1, 1'b0);
        probe(cw(2'h0, 4'h1, 2'h3, 2'h3, 1'b1) | 32'h4000000, 0, 32'h1238, 4'h8, 1'b0, 1'b1, 1'b1, 1'b1);
        probe(cw(2'h0, 4'hF, 2'h3, 2'h3, 1'b0), 0, 32'h1234, 4'hF, 1'b0, 1'b1, 1'b1, 1'b0);
        probe(cw(2'h0, 4'hF, 2'h3, 2'h3, 1'b1) | 32'h00150000, 0, 32'h1234, 4'hF, 1'b0, 1'b1, 1'b1, 1'b0);
        ctx_v = 16'h0020;
        probe(cw(2'h0, 4'hF, 2'h3, 2'h3, 1'b1) | 32'h00150000, 0, 32'h1234, 4'hF, 1'b0, 1'b1, 1'b1, 1'b1);
        $display("test lanes_link done");
    endtask : t_lanes_link
    task automatic t_irq();
        bus(1'b1, 8'h08, 32'h3, 4'hF);
        bus(1'b0, 8'h10, 32'h0, 4'hF);
        cnt_v = rd_v;
        lsu.issue(wpq_pkg::WPQ_ACC_SWAP, 32'h1234, 4'h8, 1'b1, 1'b0, 1'b0, ctx_v, 2);
        #1;
        chk(32'(irq_o), 32'h0);
        rdchk(8'h08, 32'h1);
        rdchk(8'h10, cnt_v + 32'h2);
        bus(1'b1, 8'h0C, 32'h1, 4'hF);
        rdchk(8'h0C, 32'h1);
        chk(32'(irq_o), 32'h1);
        lsu.issue(wpq_pkg::WPQ_ACC_LOAD, 32'h1234, 4'h1, 1'b0, 1'b1, 1'b0, ctx_v, 1);
        #1;
        chk(32'(wp_event_o & irq_o), 32'h1);
        bus(1'b1, 8'h08, 32'h1, 4'hF);
        rdchk(8'h08, 32'h0);
        chk(32'(irq_o), 32'h0);
        $display("test irq done");
    endtask : t_irq
    // ====================
    // Main sequence.
    initial begin
        rst_i = 1'b1;
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
        ctx_v = 16'h0000;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_filters();
        t_lanes_link();
        t_irq();
        complete_run();
    end
endmodule : tb_top
